// >>> core/rtcim_index_map.sv
/*
 * Indexed register space, register A, divider chain and periodic tap of the clock block.
 * Assumes single-cycle I/O read and write strobes on clk, and an asynchronous
 * 32.768 kHz oscillator and resume-well reset arriving on pins.
 */
// What this block does
// (RL1) Two indexed banks, each with its own index and target port pair.
// (RL2) Standard bank holds time, alarm, calendar bytes and registers A to D.
// (RL3) Standard indices 0Eh to 7Fh are 114 bytes of user RAM.
// (RL4) No reset ever alters bits 6:0 of register A; reset clears the update flag in bit 7.
// (RL5) In normal running, update flag low guarantees no update cycle for 492 microseconds.
// (RL6) Time, calendar and alarm bytes are stable whenever update flag reads low.
// (RL7) Update flag is high when an update is near or running.
// (RL8) Divider select bits 6:4; 010 runs normally, 11x holds divider reset.
// (RL9) Codes 101, 100, 011 bypass 15, 10, 5 stages; 001, 000 invalid.
// (RL10) Rate select bits 3:0 pick one of 13 taps of 15 stages.
// (RL11) Tap raises interrupt when periodic enable set, else only sets flag.
// (RL12) Rate select 0000 disables the periodic tap completely.
// (RL13) Periods double from 122.070 us to 500 ms; 0001, 0010 alias 1000, 1001.
// (RL14) Software should zero rate select when periodic interrupt unused.
// (RL15) Extended bank reached through an index port and following data port.
// (RL16) Periodic enable in register B allows interrupt; resume-well reset clears it.
// (RL17) Target access uses the index last written to its bank's index port.
// (RL18) While divider is held in reset, no update starts and flag stays clear.
module rtcim_index_map (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Host I/O port access
   input wire logic [7:0] ioAddr,
   input wire logic ioWrite,
   input wire logic ioRead,
   input wire logic [7:0] ioWData,
   output logic [7:0] ioRData_q,
   // Pins
   input wire logic oscIn,
   input wire logic resume_well_reset,
   // Events toward update and alarm logic
   output logic updateStart_q,
   output logic periodicIrq_q,
   output logic nmiMask_q
);
   // Storage, no reset: battery-backed contents
   logic [7:0] stdRam [rtcim_pkg::BANK_BYTES];
   logic [7:0] extRam [rtcim_pkg::BANK_BYTES];
   logic [6:0] rateDivCfg_q;
   logic [6:0] rateDivCfg_d;
   // Index pointers and read data
   logic [6:0] stdIndex_q;
   logic [6:0] stdIndex_d;
   logic [6:0] extIndex_q;
   logic [6:0] extIndex_d;
   logic nmiMask_d;
   logic [7:0] ioRData_d;
   // Pin synchronisers
   logic oscMeta_q;
   logic oscSync_q;
   logic oscLast_q;
   logic rwrMeta_q;
   logic rwrSync_q;
   // Divider state
   logic [14:0] chain_q;
   logic [14:0] chain_d;
   logic uip_q;
   logic uip_d;
   logic updateStart_d;
   logic pie_q;
   logic pie_d;
   logic pf_q;
   logic pf_d;
   logic periodicIrq_d;
   // Decoded strobes and helpers
   logic oscTick;
   logic stdTgtWr;
   logic extTgtWr;
   logic stdTgtRd;
   logic [2:0] divSel;
   logic [3:0] rateSel;
   logic divHeld;
   logic [15:0] chainSum;
   logic [14:0] chainStep;
   logic tapHit;
   logic [14:0] tapMask;
   logic [7:0] stdReadVal;

   // Pin inputs pass two flops before use
   // The resume-well sync starts asserted, so the periodic enable stays
   // clear until the pin has really been seen released
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         oscMeta_q <= 1'b0;
         oscSync_q <= 1'b0;
         oscLast_q <= 1'b0;
         rwrMeta_q <= 1'b1;
         rwrSync_q <= 1'b1;
      end else begin
         oscMeta_q <= oscIn;
         oscSync_q <= oscMeta_q;
         oscLast_q <= oscSync_q;
         rwrMeta_q <= resume_well_reset;
         rwrSync_q <= rwrMeta_q;
      end
   end

   // Port decode and register A fields
   always_comb begin
      oscTick = oscSync_q && !oscLast_q;
      stdTgtWr = ioWrite && (ioAddr == rtcim_pkg::STD_TARGET_PORT); // [RL1]
      extTgtWr = ioWrite && (ioAddr == rtcim_pkg::EXT_TARGET_PORT); // [RL15]
      stdTgtRd = ioRead && (ioAddr == rtcim_pkg::STD_TARGET_PORT);
      divSel = rateDivCfg_q[rtcim_pkg::DIVSEL_MSB:rtcim_pkg::DIVSEL_LSB];
      rateSel = rateDivCfg_q[rtcim_pkg::RATESEL_MSB:rtcim_pkg::RATESEL_LSB];
      divHeld = (divSel[2:1] == rtcim_pkg::DIVSEL_RESET_TOP); // [RL8]
   end

   // Index pointers follow writes to the index ports
   always_comb begin
      stdIndex_d = stdIndex_q;
      extIndex_d = extIndex_q;
      nmiMask_d = nmiMask_q;
      if (ioWrite && (ioAddr == rtcim_pkg::STD_INDEX_PORT)) begin
         stdIndex_d = ioWData[6:0]; // [RL17]
         nmiMask_d = ioWData[rtcim_pkg::NMI_MASK_BIT];
      end
      if (ioWrite && (ioAddr == rtcim_pkg::EXT_INDEX_PORT)) begin
         extIndex_d = ioWData[6:0]; // [RL15] [RL17]
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stdIndex_q <= 7'h00;
         extIndex_q <= 7'h00;
         nmiMask_q <= 1'b0;
      end else begin
         stdIndex_q <= stdIndex_d;
         extIndex_q <= extIndex_d;
         nmiMask_q <= nmiMask_d;
      end
   end

   // Register A: only host writes change it, never a reset
   always_comb begin
      rateDivCfg_d = rateDivCfg_q;
      if (stdTgtWr && (stdIndex_q == rtcim_pkg::RATE_DIVIDER_CONFIG)) begin
         rateDivCfg_d = ioWData[6:0]; // Bit 7 is status only
      end
   end

   // Register A lives in the battery well: a host reset that cleared it
   // would silently stop the divider or change the periodic rate
   always_ff @(posedge clk) begin
      rateDivCfg_q <= rateDivCfg_d; // [RL4]
   end

   // Byte storage for both banks; time bytes change only by host write
   always_ff @(posedge clk) begin
      if (stdTgtWr) begin
         stdRam[stdIndex_q] <= ioWData; // [RL2] [RL3] [RL6] [RL17]
      end
      if (extTgtWr) begin
         extRam[extIndex_q] <= ioWData; // [RL15] [RL17]
      end
   end

   // Divider chain step: bypass modes skip low stages
   always_comb begin
      unique case (divSel)
         rtcim_pkg::DIVSEL_NORMAL: chainStep = 15'h0001;
         rtcim_pkg::DIVSEL_BYP5: chainStep = 15'h0020; // [RL9]
         rtcim_pkg::DIVSEL_BYP10: chainStep = 15'h0400; // [RL9]
         rtcim_pkg::DIVSEL_BYP15: chainStep = 15'h0000; // [RL9] Every tick wraps
         default: chainStep = 15'h0000; // Invalid or reset codes
      endcase
      chainSum = {1'b0, chain_q} + {1'b0, chainStep};
      if (divSel == rtcim_pkg::DIVSEL_BYP15) begin
         chainSum = 16'h8000;
      end
   end

   // Chain advance, update start and update-pending flag
   // Bypass codes shorten the second, so the guard window ahead of an
   // update holds only in normal running; test modes may cut it short.
   // Leaving divider reset starts the chain at zero inside the busy span,
   // so the flag reads high briefly although no update follows
   always_comb begin
      chain_d = chain_q;
      updateStart_d = 1'b0;
      uip_d = uip_q;
      if (divHeld) begin
         chain_d = rtcim_pkg::DIVIDER_RESET_VALUE; // [RL8]
         uip_d = 1'b0; // [RL18]
      end else if (oscTick && (chainStep != 15'h0000 ||
                               divSel == rtcim_pkg::DIVSEL_BYP15)) begin
         chain_d = chainSum[14:0];
         // Wrap of the last stage is the one-second update point
         updateStart_d = chainSum[15] &&
                         !stdRam[rtcim_pkg::GENERAL_CONFIG][rtcim_pkg::UPDATE_INHIBIT_BIT];
         // High from the guard window through the short busy span after wrap
         uip_d = (chain_d >= rtcim_pkg::UIP_RISE_COUNT) ||
                 (chain_d < rtcim_pkg::UPDATE_BUSY_TICKS); // [RL5] [RL7]
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         chain_q <= rtcim_pkg::DIVIDER_RESET_VALUE;
         uip_q <= 1'b0;
         updateStart_q <= 1'b0;
      end else begin
         chain_q <= chain_d;
         uip_q <= uip_d;
         updateStart_q <= updateStart_d;
      end
   end

   // Periodic tap: rate codes map onto chain stages
   // Only a real chain step may hit a tap: with an invalid divider code
   // the chain is frozen and would otherwise fire on every tick
   always_comb begin
      unique case (rateSel)
         4'h1: tapMask = 15'h007f; // [RL13] Same as 1000
         4'h2: tapMask = 15'h00ff; // [RL13] Same as 1001
         default: tapMask = 15'((16'h0001 << (rateSel - 4'h1)) - 16'h0001); // [RL10] [RL13]
      endcase
      tapHit = oscTick && !divHeld && (rateSel != rtcim_pkg::RATESEL_OFF) &&
               ((chain_d & tapMask) == 15'h0000) && (chain_d != chain_q ||
               divSel == rtcim_pkg::DIVSEL_BYP15); // [RL12]
   end

   // Periodic flag, enable and interrupt; set wins over read-clear
   // A tap landing in the cycle of a status read keeps the flag, so the
   // host loses no event between reading and clearing
   always_comb begin
      pie_d = pie_q;
      pf_d = pf_q;
      if (stdTgtWr && (stdIndex_q == rtcim_pkg::GENERAL_CONFIG)) begin
         pie_d = ioWData[rtcim_pkg::PERIODIC_IRQ_ENABLE_BIT];
      end
      if (rwrSync_q) begin
         pie_d = 1'b0; // [RL16]
      end
      if (stdTgtRd && (stdIndex_q == rtcim_pkg::EVENT_FLAGS)) begin
         pf_d = 1'b0;
      end
      if (tapHit) begin
         pf_d = 1'b1; // [RL11]
      end
      periodicIrq_d = pf_d && pie_d; // [RL11] [RL16]
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pie_q <= 1'b0;
         pf_q <= 1'b0;
         periodicIrq_q <= 1'b0;
      end else begin
         pie_q <= pie_d;
         pf_q <= pf_d;
         periodicIrq_q <= periodicIrq_d;
      end
   end

   // Read data mux for the standard bank
   // Live status replaces the stored copy for registers A to C, so the
   // host always reads the flag and enable the logic is acting on
   always_comb begin
      stdReadVal = stdRam[stdIndex_q];
      unique case (stdIndex_q)
         rtcim_pkg::RATE_DIVIDER_CONFIG: stdReadVal = {uip_q, rateDivCfg_q}; // [RL7]
         rtcim_pkg::GENERAL_CONFIG: begin
            stdReadVal[rtcim_pkg::PERIODIC_IRQ_ENABLE_BIT] = pie_q;
         end
         rtcim_pkg::EVENT_FLAGS: begin
            stdReadVal = 8'h00;
            stdReadVal[rtcim_pkg::IRQ_REQUEST_BIT] = periodicIrq_q;
            stdReadVal[rtcim_pkg::PERIODIC_FLAG_BIT] = pf_q;
         end
         default: stdReadVal = stdRam[stdIndex_q];
      endcase
   end

   // Registered read data for each port
   // Data holds between reads, so the host may sample it late
   always_comb begin
      ioRData_d = ioRData_q;
      if (ioRead) begin
         unique case (ioAddr)
            rtcim_pkg::STD_INDEX_PORT: ioRData_d = {nmiMask_q, stdIndex_q};
            rtcim_pkg::STD_TARGET_PORT: ioRData_d = stdReadVal; // [RL1] [RL17]
            rtcim_pkg::EXT_INDEX_PORT: ioRData_d = {1'b0, extIndex_q};
            rtcim_pkg::EXT_TARGET_PORT: ioRData_d = extRam[extIndex_q]; // [RL15]
            default: ioRData_d = 8'hff; // Unmapped port
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ioRData_q <= 8'h00;
      end else begin
         ioRData_q <= ioRData_d;
      end
   end
endmodule

// >>> dv/rtcim_index_map_assertions.sv
/* Checker for the clock block's index map and rate divider.
   Assumes the index port is written before its target port. */
module rtcim_index_map_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Host access
   input wire logic [7:0] ioAddr,
   input wire logic ioWrite,
   input wire logic ioRead,
   input wire logic [7:0] ioWData,
   input wire logic [7:0] ioRData_q,
   // Pins and events
   input wire logic oscIn,
   input wire logic resume_well_reset,
   input wire logic updateStart_q,
   input wire logic periodicIrq_q,
   input wire logic nmiMask_q
);
   logic [6:0] idx_q;
   logic [7:0] regA_q;
   logic inhibit_q;
   logic tgtWr;
   // Shadow of the standard index
   assign tgtWr = ioWrite && ioAddr == 8'h71;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) idx_q <= 7'h00;
      else if (ioWrite && ioAddr == 8'h70) idx_q <= ioWData[6:0];
   end
   // Shadow of register A and update inhibit, never reset like the real ones
   always_ff @(posedge clk) begin
      if (tgtWr && idx_q == 7'h0a) regA_q <= ioWData;
      if (tgtWr && idx_q == 7'h0b) inhibit_q <= ioWData[7];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Steps of the watched behaviours
   sequence s_regcRead;
      ioRead && ioAddr == 8'h71 && idx_q == 7'h0c && !$past(ioRead && ioAddr == 8'h71);
   endsequence
   sequence s_bypassTick;
      $rose(oscIn) && regA_q[6:4] == 3'h5 && !inhibit_q;
   endsequence
   sequence s_rateOffQuiet;
      (regA_q[3:0] == 4'h0 && !tgtWr)[*3] ##0 !periodicIrq_q;
   endsequence
   property p_unmapRead;
      ioRead && ioAddr[7:2] != 6'h1c |=> ioRData_q == 8'hff;
   endproperty
   a_unmapRead: assert property (p_unmapRead) else $error("unmapped read not ff");
   property p_nmiSet;
      ioWrite && ioAddr == 8'h70 |=> nmiMask_q == $past(ioWData[7]);
   endproperty
   a_nmiSet: assert property (p_nmiSet) else $error("nmi mask not taken");
   property p_regARead;
      ioRead && ioAddr == 8'h71 && idx_q == 7'h0a && regA_q[6:5] == 2'h3
         |=> ioRData_q == {1'b0, $past(regA_q[6:0])};
   endproperty
   a_regARead: assert property (p_regARead) else $error("register A read wrong");
   property p_divReset;
      (regA_q[6:5] == 2'h3)[*4] |-> !updateStart_q;
   endproperty
   a_divReset: assert property (p_divReset) else $error("update while held");
   property p_bypassUpd;
      s_bypassTick |-> ##[2:6] (updateStart_q || regA_q[6:4] != 3'h5);
   endproperty
   a_bypassUpd: assert property (p_bypassUpd) else $error("no update on tick");
   property p_pirqRegC;
      s_regcRead ##0 periodicIrq_q |=> ioRData_q[6];
   endproperty
   a_pirqRegC: assert property (p_pirqRegC) else $error("flag not in status");
   property p_rateOff;
      s_rateOffQuiet |=> !periodicIrq_q;
   endproperty
   a_rateOff: assert property (p_rateOff) else $error("event with rate off");
   property p_rwrClear;
      resume_well_reset[*6] |-> !periodicIrq_q;
   endproperty
   a_rwrClear: assert property (p_rwrClear) else $error("enable survived");
endmodule

bind rtcim_index_map rtcim_index_map_checker u_chk (.clk(clk), .rst_b(rst_b),
   .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead), .ioWData(ioWData),
   .ioRData_q(ioRData_q), .oscIn(oscIn), .resume_well_reset(resume_well_reset),
   .updateStart_q(updateStart_q), .periodicIrq_q(periodicIrq_q), .nmiMask_q(nmiMask_q));

// >>> dv/rtcim_index_map_tb_top.sv
/* Testbench for the clock block's index map and rate divider.
   Assumes the oscillator model ticks every 8 system clocks. */
module rtcim_index_map_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_b, ioWrite, ioRead, oscIn, rwr, updSeen;
   logic [7:0] ioAddr, ioWData, ioRData_q, rd;
   logic updateStart_q, periodicIrq_q, nmiMask_q;
   int miscompares, n_tests;
   time t1;
   int idxs [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 14, 127};
   rtcim_index_map u_dut (.clk(clk), .rst_b(rst_b), .ioAddr(ioAddr), .ioWrite(ioWrite),
      .ioRead(ioRead), .ioWData(ioWData), .ioRData_q(ioRData_q), .oscIn(oscIn),
      .resume_well_reset(rwr), .updateStart_q(updateStart_q),
      .periodicIrq_q(periodicIrq_q), .nmiMask_q(nmiMask_q));
   rtcim_osc_model u_osc (.oscIn(oscIn));
   // Clock
   always #50 clk = ~clk;
   // Verdict and end of run
   task automatic complete_run();
      $display("Checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
         miscompares++;
      end
   endtask
   // One port access; read data taken the cycle after the strobe
   task automatic io(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      ioAddr = a;
      ioWData = d;
      ioWrite = wr;
      ioRead = !wr;
      @(posedge clk);
      #1;
      ioWrite = 1'b0;
      ioRead = 1'b0;
      rd = ioRData_q;
   endtask
   task automatic reg_wr(input logic [7:0] base, input logic [6:0] i, input logic [7:0] d);
      io(1'b1, base, {1'b0, i});
      io(1'b1, base + 8'h01, d);
   endtask
   task automatic reg_rd(input logic [7:0] base, input logic [6:0] i, input logic [7:0] e);
      io(1'b1, base, {1'b0, i});
      io(1'b0, base + 8'h01, 8'h00);
      check(rd, e);
   endtask
   // Bounded wait for the update pulse (0) or periodic request (1)
   task automatic wait_hi(input int which, input int lim);
      for (int k = 0; k < lim; k++) begin
         if ((which == 1 ? periodicIrq_q : updateStart_q) === 1'b1) return;
         @(posedge clk);
         #1;
      end
      miscompares++;
      complete_run();
   endtask
   task automatic clr_flag();
      io(1'b1, 8'h70, 8'h0c);
      io(1'b0, 8'h71, 8'h00);
      @(posedge clk);
      #1;
   endtask
   // Main sequence
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      ioWrite = 1'b0;
      ioRead = 1'b0;
      ioAddr = 8'h00;
      ioWData = 8'h00;
      rwr = 1'b0;
      miscompares = 0;
      n_tests = 0;
      repeat (5) @(posedge clk);
      #1;
      rst_b = 1'b1;
      reg_wr(8'h70, 7'h0a, 8'he3);
      reg_rd(8'h70, 7'h0a, 8'h63);
      foreach (idxs[i]) reg_wr(8'h70, 7'(idxs[i]), 8'(idxs[i]) ^ 8'h5a);
      foreach (idxs[i]) reg_wr(8'h72, 7'(idxs[i]), 8'(idxs[i]) ^ 8'ha5);
      foreach (idxs[i]) begin
         reg_rd(8'h70, 7'(idxs[i]), 8'(idxs[i]) ^ 8'h5a);
         reg_rd(8'h72, 7'(idxs[i]), 8'(idxs[i]) ^ 8'ha5);
      end
      io(1'b0, 8'h74, 8'h00);
      check(rd, 8'hff);
      io(1'b1, 8'h70, 8'h8e);
      check({7'h00, nmiMask_q}, 8'h01);
      // A second reset must leave register A alone
      rst_b = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rst_b = 1'b1;
      reg_rd(8'h70, 7'h0a, 8'h63);
      updSeen = 1'b0;
      repeat (200) begin
         @(posedge clk);
         #1;
         updSeen = updSeen | updateStart_q;
      end
      check({7'h00, updSeen}, 8'h00);
      // Bypass of all stages: every tick ends a second
      reg_wr(8'h70, 7'h0b, 8'h40);
      reg_wr(8'h70, 7'h0a, 8'h50);
      wait_hi(0, 40);
      // Normal running at the fastest rate: four ticks apart
      reg_wr(8'h70, 7'h0a, 8'h23);
      clr_flag();
      wait_hi(1, 400);
      t1 = $time;
      reg_rd(8'h70, 7'h0c, 8'hc0);
      @(posedge clk);
      #1;
      check({7'h00, periodicIrq_q}, 8'h00);
      wait_hi(1, 400);
      check(8'(($time - t1) / 100), 8'h20);
      // Rate 0001 repeats the period of 1000: 128 ticks of 800 ns apart
      reg_wr(8'h70, 7'h0a, 8'h21);
      clr_flag();
      wait_hi(1, 1100);
      t1 = $time;
      reg_rd(8'h70, 7'h0c, 8'hc0);
      wait_hi(1, 1100);
      check(8'(($time - t1) / 800), 8'h80);
      // Rate zero stops all periodic events
      reg_wr(8'h70, 7'h0a, 8'h20);
      clr_flag();
      repeat (200) @(posedge clk);
      reg_rd(8'h70, 7'h0c, 8'h00);
      // Resume-well reset drops the periodic enable
      reg_wr(8'h70, 7'h0a, 8'h23);
      wait_hi(1, 400);
      rwr = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      rwr = 1'b0;
      check({7'h00, periodicIrq_q}, 8'h00);
      reg_rd(8'h70, 7'h0b, 8'h00);
      // Full bypass zeroes the chain, five-stage bypass climbs near the top
      reg_wr(8'h70, 7'h0a, 8'h50);
      wait_hi(0, 40);
      reg_wr(8'h70, 7'h0a, 8'h30);
      repeat (8000) @(posedge clk);
      reg_wr(8'h70, 7'h0a, 8'h20);
      // Poll the update flag, then time the update that follows it
      io(1'b1, 8'h70, 8'h0a);
      rd = 8'h00;
      for (int k = 0; k < 5000 && !rd[7]; k++) io(1'b0, 8'h71, 8'h00);
      check(rd, 8'ha0);
      t1 = $time;
      wait_hi(0, 400);
      // At least 17 ticks of 800 ns between flag and update
      check({7'h00, ($time - t1) >= 64'h3520}, 8'h01);
      io(1'b0, 8'h71, 8'h00);
      check(rd, 8'ha0);
      repeat (30) @(posedge clk);
      io(1'b0, 8'h71, 8'h00);
      check(rd, 8'h20);
      reg_rd(8'h70, 7'h00, 8'h5a);
      complete_run();
   end
endmodule

// >>> dv/rtcim_osc_model.sv
/* Free-running oscillator standing in for the crystal pin.
   Assumes a fast test rate so one tick spans a few system clocks. */
module rtcim_osc_model #(
   parameter int HALF_NS = 400,
   parameter int START_NS = 37
) (
   // Oscillator pin
   output logic oscIn
);
   timeunit 1ns;
   timeprecision 1ns;
   // Square wave, out of phase with the system clock
   initial begin
      oscIn = 1'b0;
      #START_NS;
      forever #HALF_NS oscIn = ~oscIn;
   end
endmodule

// >>> shared/rtcim_pkg.sv
/*
 * Constants for the indexed register space and rate divider of the clock block.
 * Assumes a 10 MHz system clock and a 32.768 kHz oscillator pin.
 */
package rtcim_pkg;
   // I/O port addresses
   localparam logic [7:0] STD_INDEX_PORT = 8'h70;
   localparam logic [7:0] STD_TARGET_PORT = 8'h71;
   localparam logic [7:0] EXT_INDEX_PORT = 8'h72;
   localparam logic [7:0] EXT_TARGET_PORT = 8'h73;
   // Standard bank indices
   localparam logic [6:0] SECONDS_COUNT = 7'h00;
   localparam logic [6:0] SECONDS_ALARM = 7'h01;
   localparam logic [6:0] MINUTES_COUNT = 7'h02;
   localparam logic [6:0] MINUTES_ALARM = 7'h03;
   localparam logic [6:0] HOURS_COUNT = 7'h04;
   localparam logic [6:0] HOURS_ALARM = 7'h05;
   localparam logic [6:0] WEEKDAY_COUNT = 7'h06;
   localparam logic [6:0] MONTHDAY_COUNT = 7'h07;
   localparam logic [6:0] MONTH_COUNT = 7'h08;
   localparam logic [6:0] YEAR_COUNT = 7'h09;
   localparam logic [6:0] RATE_DIVIDER_CONFIG = 7'h0a;
   localparam logic [6:0] GENERAL_CONFIG = 7'h0b;
   localparam logic [6:0] EVENT_FLAGS = 7'h0c;
   localparam logic [6:0] VALIDITY_STATUS = 7'h0d;
   localparam logic [6:0] USER_RAM_FIRST = 7'h0e;
   localparam int USER_RAM_BYTES = 114;
   localparam int BANK_BYTES = 128;
   // Field positions
   localparam int UPDATE_PENDING_BIT = 7;
   localparam int DIVSEL_MSB = 6;
   localparam int DIVSEL_LSB = 4;
   localparam int RATESEL_MSB = 3;
   localparam int RATESEL_LSB = 0;
   localparam int UPDATE_INHIBIT_BIT = 7;
   localparam int PERIODIC_IRQ_ENABLE_BIT = 6;
   localparam int PERIODIC_FLAG_BIT = 6;
   localparam int IRQ_REQUEST_BIT = 7;
   localparam int NMI_MASK_BIT = 7;
   // Divider select codes
   localparam logic [2:0] DIVSEL_NORMAL = 3'h2;
   localparam logic [2:0] DIVSEL_BYP5 = 3'h3;
   localparam logic [2:0] DIVSEL_BYP10 = 3'h4;
   localparam logic [2:0] DIVSEL_BYP15 = 3'h5;
   localparam logic [1:0] DIVSEL_RESET_TOP = 2'h3;
   localparam logic [3:0] RATESEL_OFF = 4'h0;
   // Divider chain and timing
   localparam int CHAIN_STAGES = 15;
   localparam int OSC_HZ = 32768;
   localparam int UIP_GUARD_US = 492;
   localparam int UIP_GUARD_TICKS = (UIP_GUARD_US * OSC_HZ + 999999) / 1000000;
   localparam logic [14:0] UIP_RISE_COUNT = 15'(32768 - UIP_GUARD_TICKS - 1);
   localparam logic [14:0] UPDATE_BUSY_TICKS = 15'h0002;
   localparam logic [14:0] DIVIDER_RESET_VALUE = 15'h0000;
endpackage
